// [hdl/hbfp_regs.svh]
/*
 Register offsets, reset values, event bit positions and timing counts of the bridge fault block.
 Assumes inclusion by its bare name from the top module and the bench.
*/
`ifndef HBFP_REGS_SVH
`define HBFP_REGS_SVH
`define HBFP_ADDR_W 12
`define HBFP_OFS_CTRL 12'h000
`define HBFP_OFS_STATUS 12'h004
`define HBFP_OFS_INT_STAT 12'h008
`define HBFP_OFS_INT_MASK 12'h00c
`define HBFP_CTRL_INHIBIT 0
`define HBFP_CTRL_RESET 1'h0
`define HBFP_INT_RESET 4'h0
`define HBFP_MASK_RESET 4'h0
`define HBFP_EV_SHORT 0
`define HBFP_EV_OTEMP 1
`define HBFP_EV_CLIMIT 2
`define HBFP_EV_UVOLT 3
`define HBFP_CLK_PERIOD_PS 5000
`define HBFP_T_OFF_US 20
`define HBFP_OFF_CYCLES ((`HBFP_T_OFF_US * 1000000) / `HBFP_CLK_PERIOD_PS)
`endif

// [hdl/hbfp_pkg.sv]
/*
 Types shared by the bridge fault block: sense bundle, event bundle, status layout and drive modes.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package hbfp_pkg;
    typedef struct packed {
        logic uvolt;
        logic temp_release;
        logic temp_shut;
        logic temp_fold;
        logic cur_limit;
        logic short_det;
    } hbfp_sense_t;

    typedef struct packed {
        logic uvolt;
        logic climit;
        logic otemp;
        logic short_ev;
    } hbfp_event_t;

    typedef struct packed {
        logic fold;
        logic climit_busy;
        logic uvolt;
        logic otemp_latched;
        logic short_latched;
    } hbfp_status_t;

    typedef enum logic [2:0] {
        MODE_SLEEP,
        MODE_FAULT,
        MODE_UVOLT,
        MODE_DISABLED,
        MODE_INHIBIT,
        MODE_CLIMIT,
        MODE_RUN
    } hbfp_mode_t;
endpackage : hbfp_pkg
`default_nettype wire

// [hdl/hbfp_sync.sv]
/*
 Two flip-flop synchroniser for a bundle of independent level inputs.
 Assumes each bit is a slow level; multi-bit coherence is not kept.
*/
`timescale 1ns/1ps
`default_nettype none
module hbfp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Levels
    input wire logic [WIDTH-1:0] d_async,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d_async;
            q <= meta;
        end
    end
endmodule : hbfp_sync
`default_nettype wire

// [hdl/hbfp_off_timer.sv]
/*
 Fixed off-time timer: a start pulse holds busy high for COUNT cycles.
 Assumes start is ignored while busy.
*/
`timescale 1ns/1ps
`default_nettype none
module hbfp_off_timer #(
    parameter int COUNT = 4000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    output logic busy
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LOAD = CW'(COUNT - 1);
    logic [CW-1:0] remain;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            remain <= '0;
            busy <= 1'b0;
        end
        else if (start && !busy)
        begin
            remain <= LOAD;
            busy <= 1'b1;
        end
        else if (busy)
        begin
            if (remain == '0)
                busy <= 1'b0;
            else
                remain <= remain - 1'b1;
        end
    end
endmodule : hbfp_off_timer
`default_nettype wire

// [hdl/hbfp_top.sv]
/*
 Fault protection and drive logic of a two-output motor bridge, with an APB register slave.
 Assumes the analog sense comparators deliver asynchronous levels and that presetn follows supply power.
*/
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hbfp_regs.svh"

// Summary of operation
// - Detected short latches both outputs off and pulls the fault flag low.
// - Short latch clears only on disable falling or enable rising edge.
// - After clearing, outputs follow the present input pin levels.
// - Reaching current limit turns outputs off for a fixed 20 us.
// - Above 160 degrees the reduced 4.2 A current limit is selected.
// - Above 175 degrees overtemperature is detected and outputs shut down.
// - Overtemperature latches outputs off with the fault flag low.
// - Overtemperature latch resets on disable falling or enable rising edge.
// - Enable edge clears below threshold; disable edge only below threshold minus hysteresis.
// - Fault reset and power cycling return the flag high.
// - Undervoltage turns outputs off, flag low, recovering automatically.
// - Disable high: outputs off, flag low; enable low: outputs off, sleep.
// - Enabled, each output follows its own polarity input.
module hbfp_top #(
    parameter int OFF_CYCLES = `HBFP_OFF_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`HBFP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control pins
    input wire logic polarity_in_a,
    input wire logic polarity_in_b,
    input wire logic disable_hi,
    input wire logic enable_sleep_n,
    // Analog sense levels
    input wire hbfp_pkg::hbfp_sense_t sense_async,
    // Bridge outputs
    output logic bridge_out_a,
    output logic bridge_out_a_oe,
    output logic bridge_out_b,
    output logic bridge_out_b_oe,
    // Open-drain fault flag and threshold select
    output logic fault_status_n_out,
    output logic fault_status_n_oe,
    output logic current_limit_reduced,
    // Interrupt
    output logic irq
);
    import hbfp_pkg::*;

    hbfp_sense_t s_sense;
    logic s_in_a;
    logic s_in_b;
    logic s_dis;
    logic s_en;
    logic dis_q;
    logic en_q;
    logic dis_fall;
    logic en_rise;
    logic short_latched;
    logic otemp_latched;
    logic climit_busy;
    logic climit_start;
    logic uv_q;
    logic inhibit;
    hbfp_mode_t mode;
    hbfp_mode_t next_mode;
    hbfp_event_t events;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    hbfp_status_t status;
    logic bus_access;
    logic bus_wr;
    logic hit_ctrl;
    logic hit_status;
    logic hit_stat;
    logic hit_mask;
    logic [31:0] next_rdata;

    hbfp_sync #(
        .WIDTH(10)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d_async({sense_async, polarity_in_a, polarity_in_b, disable_hi, enable_sleep_n}),
        .q({s_sense, s_in_a, s_in_b, s_dis, s_en})
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dis_q <= 1'b0;
            en_q <= 1'b0;
        end
        else
        begin
            dis_q <= s_dis;
            en_q <= s_en;
        end
    end

    assign dis_fall = dis_q && !s_dis;
    assign en_rise = !en_q && s_en;

    // edge-only clearing; a new short in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            short_latched <= 1'b0;
        else if (s_sense.short_det)
            short_latched <= 1'b1;
        else if (dis_fall || en_rise)
            short_latched <= 1'b0;
    end

    // enable edge needs below threshold, disable edge below hysteresis point
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            otemp_latched <= 1'b0;
        else if (s_sense.temp_shut)
            otemp_latched <= 1'b1;
        else if (en_rise || (dis_fall && !s_sense.temp_release))
            otemp_latched <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            current_limit_reduced <= 1'b0;
        else
            current_limit_reduced <= s_sense.temp_fold;
    end

    assign climit_start = s_sense.cur_limit && (mode == MODE_RUN) && !climit_busy;

    hbfp_off_timer #(
        .COUNT(OFF_CYCLES)
    ) u_off (
        .pclk(pclk),
        .presetn(presetn),
        .start(climit_start),
        .busy(climit_busy)
    );

    // Sleep is checked first so a sleeping device keeps its flag released even with a latched fault.
    // sleep and disable priority
    // enabled with no latch, undervoltage, disable, inhibit or off time selects the input-defined mode
    always_comb
    begin
        if (!s_en)
            next_mode = MODE_SLEEP;
        else if (short_latched || otemp_latched)
            next_mode = MODE_FAULT;
        else if (s_sense.uvolt)
            next_mode = MODE_UVOLT;
        else if (s_dis)
            next_mode = MODE_DISABLED;
        else if (inhibit)
            next_mode = MODE_INHIBIT;
        else if (climit_busy)
            next_mode = MODE_CLIMIT;
        else
            next_mode = MODE_RUN;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode <= MODE_SLEEP;
        else
            mode <= next_mode;
    end

    // fault mode drives the flag low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bridge_out_a <= 1'b0;
            bridge_out_b <= 1'b0;
            bridge_out_a_oe <= 1'b0;
            bridge_out_b_oe <= 1'b0;
            fault_status_n_oe <= 1'b0;
        end
        else
        begin
            bridge_out_a <= 1'b0;
            bridge_out_b <= 1'b0;
            bridge_out_a_oe <= 1'b0;
            bridge_out_b_oe <= 1'b0;
            fault_status_n_oe <= 1'b0;
            case (mode)
                MODE_RUN:
                begin
                    bridge_out_a <= s_in_a;
                    bridge_out_b <= s_in_b;
                    bridge_out_a_oe <= 1'b1;
                    bridge_out_b_oe <= 1'b1;
                end
                MODE_FAULT, MODE_UVOLT, MODE_DISABLED:
                    fault_status_n_oe <= 1'b1;
                default:
                    fault_status_n_oe <= 1'b0;
            endcase
        end
    end

    // The flag pin only ever pulls low, so its data bit is a constant-low flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_status_n_out <= 1'b0;
        else
            fault_status_n_out <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            uv_q <= 1'b0;
        else
            uv_q <= s_sense.uvolt;
    end

    assign events.short_ev = s_sense.short_det && !short_latched;
    assign events.otemp = s_sense.temp_shut && !otemp_latched;
    assign events.climit = climit_start;
    assign events.uvolt = s_sense.uvolt && !uv_q;

    assign status.fold = current_limit_reduced;
    assign status.climit_busy = climit_busy;
    assign status.uvolt = s_sense.uvolt;
    assign status.otemp_latched = otemp_latched;
    assign status.short_latched = short_latched;

    // Zero-wait decode is avoided: pready is registered, so every access lasts two access cycles.
    assign bus_access = psel && penable && !pready;
    assign bus_wr = bus_access && pwrite && pstrb[0];

    always_comb
    begin
        hit_ctrl = 1'b0;
        hit_status = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        next_rdata = 32'h0000_0000;
        if (paddr == `HBFP_OFS_CTRL)
        begin
            hit_ctrl = 1'b1;
            next_rdata = {31'h0000_0000, inhibit};
        end
        else if (paddr == `HBFP_OFS_STATUS)
        begin
            hit_status = 1'b1;
            next_rdata = {27'h000_0000, status};
        end
        else if (paddr == `HBFP_OFS_INT_STAT)
        begin
            hit_stat = 1'b1;
            next_rdata = {28'h000_0000, int_stat};
        end
        else if (paddr == `HBFP_OFS_INT_MASK)
        begin
            hit_mask = 1'b1;
            next_rdata = {28'h000_0000, int_mask};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= bus_access;
            pslverr <= bus_access && !(hit_ctrl || hit_status || hit_stat || hit_mask);
            if (bus_access && !pwrite)
                prdata <= next_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            inhibit <= `HBFP_CTRL_RESET;
        else if (bus_wr && hit_ctrl)
            inhibit <= pwdata[`HBFP_CTRL_INHIBIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_mask <= `HBFP_MASK_RESET;
        else if (bus_wr && hit_mask)
            int_mask <= pwdata[3:0];
    end

    // A fresh event outranks a write-one-to-clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_stat <= `HBFP_INT_RESET;
        else if (bus_wr && hit_stat)
            int_stat <= (int_stat & ~pwdata[3:0]) | events;
        else
            int_stat <= int_stat | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(int_stat & int_mask);
    end

    short_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        short_latched |-> ##2 (!bridge_out_a_oe && !bridge_out_b_oe))
        else $error("short latch did not force outputs off");

    short_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (short_latched && !s_sense.short_det && !dis_fall && !en_rise) |=> short_latched)
        else $error("short latch cleared without a control edge");

    run_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_RUN) |=> (bridge_out_a_oe && bridge_out_a == $past(s_in_a) && bridge_out_b == $past(s_in_b)))
        else $error("outputs do not follow polarity inputs");

    climit_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(climit_busy) |-> climit_busy [*8] ##2 !bridge_out_a_oe)
        else $error("off time too short or outputs driven");

    fold_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_sense.temp_fold |=> current_limit_reduced)
        else $error("reduced threshold not selected");

    otemp_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (otemp_latched && s_en) |-> ##2 (fault_status_n_oe && !bridge_out_b_oe))
        else $error("overtemperature did not pull the flag low");

    otemp_hyst_a: assert property (@(posedge pclk) disable iff (!presetn)
        (otemp_latched && dis_fall && !en_rise && s_sense.temp_release) |=> otemp_latched)
        else $error("disable edge cleared overtemperature above hysteresis point");

    uv_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_en && s_sense.uvolt) |-> ##2 (fault_status_n_oe && !bridge_out_a_oe))
        else $error("undervoltage did not turn outputs off");

    sleep_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        !s_en |-> ##2 (!fault_status_n_oe && !bridge_out_a_oe && !bridge_out_b_oe))
        else $error("sleep did not release flag and outputs");

    edge_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        (dis_fall |=> !dis_fall) and (en_rise |=> !en_rise))
        else $error("one pin transition seen twice");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        |(int_stat & int_mask) |=> irq)
        else $error("interrupt not raised for unmasked status");
endmodule : hbfp_top
`default_nettype wire

// [dv/hbfp_host_model.sv]
/*
 Host side of the bridge fault block: drives the four control pins and reads the open-drain fault flag.
 Assumes the test sequence sets pin_req just after a rising edge; the pins follow one edge later.
*/
`timescale 1ns/1ps
`default_nettype none
module hbfp_host_model (
    // Clock
    input wire logic pclk,
    // Pin requests from the test sequence, {enable, disable, b, a}
    input wire logic [3:0] pin_req,
    // Control pins
    output logic polarity_in_a,
    output logic polarity_in_b,
    output logic disable_hi,
    output logic enable_sleep_n,
    // Open-drain fault flag
    input wire logic fault_status_n_out,
    input wire logic fault_status_n_oe,
    output logic flag_level
);
    // The request starts with every pin low, which keeps the bridge asleep; reset covers the first edge.
    // clearing edges driven
    always @(posedge pclk)
        {enable_sleep_n, disable_hi, polarity_in_b, polarity_in_a} <= pin_req;

    // The flag line has a pull-up, so a released flag reads high.
    assign flag_level = fault_status_n_oe ? fault_status_n_out : 1'b1;
endmodule : hbfp_host_model
`default_nettype wire

// [dv/hbfp_top_bench.sv]
/*
 Self-checking bench of the bridge fault block: APB register access, pin control and sense stimulus.
 Assumes the host model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbfp_regs.svh"
module hbfp_top_bench;
    import hbfp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`HBFP_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, irq, fold_sel;
    logic [3:0] pin_req = 4'h0;
    logic pa, pb, dis, en, flag, oe_a, oa, oe_b, ob, fo, foe;
    hbfp_sense_t sense = '0;
    logic [4:0] pin_view;
    logic [31:0] rd;
    logic er;
    int bad_count = 0;
    int checks_done = 0;

    always #2.5 pclk = ~pclk;
    // Levels are masked while a leg is high impedance.
    assign pin_view = {oe_a, oe_a & oa, oe_b, oe_b & ob, flag};

    hbfp_top #(.OFF_CYCLES(16)) u_hbfp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .polarity_in_a(pa), .polarity_in_b(pb), .disable_hi(dis), .enable_sleep_n(en),
        .sense_async(sense), .bridge_out_a(oa), .bridge_out_a_oe(oe_a), .bridge_out_b(ob), .bridge_out_b_oe(oe_b),
        .fault_status_n_out(fo), .fault_status_n_oe(foe), .current_limit_reduced(fold_sel), .irq(irq));
    hbfp_host_model u_hbfp_host_model (.pclk(pclk), .pin_req(pin_req), .polarity_in_a(pa), .polarity_in_b(pb),
        .disable_hi(dis), .enable_sleep_n(en), .fault_status_n_out(fo), .fault_status_n_oe(foe), .flag_level(flag));

    task step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(rd, exp, what);
        check({31'h0, er}, 32'h0, "no error on mapped read");
    endtask : rd_chk
    task pins(input logic [3:0] v);
        pin_req <= v;
        step(8);
    endtask : pins
    task chk_pins(input logic [4:0] exp, input string what);
        check({27'h0, pin_view}, {27'h0, exp}, what);
    endtask : chk_pins
    task done(input string name);
        $display("test %s finished", name);
    endtask : done
    task final_report;
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    initial
    begin
        step(20000);
        bad_count++;
        final_report;
    end

    initial
    begin
        step(12);
        presetn <= 1'b1;
        step(2);
        chk_pins(5'b00001, "asleep after reset");
        rd_chk(`HBFP_OFS_CTRL, 32'h0, "ctrl reset");
        rd_chk(`HBFP_OFS_STATUS, 32'h0, "status reset");
        rd_chk(`HBFP_OFS_INT_STAT, 32'h0, "event reset");
        rd_chk(`HBFP_OFS_INT_MASK, 32'h0, "mask reset");
        done("reset");
        for (int i = 0; i < 4; i++)
        begin
            pins({2'b10, i[1:0]});
            chk_pins({1'b1, i[0], 1'b1, i[1], 1'b1}, "outputs follow polarity");
        end
        pins(4'b1110);
        chk_pins(5'b00000, "disable forces off");
        done("drive");
        sense.short_det <= 1'b1;
        step(8);
        chk_pins(5'b00000, "short latches off");
        pins(4'b1010);
        chk_pins(5'b00000, "short ignores polarity");
        sense.short_det <= 1'b0;
        step(8);
        chk_pins(5'b00000, "short stays latched");
        rd_chk(`HBFP_OFS_STATUS, 32'h1, "short status");
        pins(4'b1110);
        pins(4'b1010);
        chk_pins(5'b10111, "disable fall clears short");
        rd_chk(`HBFP_OFS_STATUS, 32'h0, "status after clear");
        sense.short_det <= 1'b1;
        step(8);
        sense.short_det <= 1'b0;
        step(8);
        chk_pins(5'b00000, "old edge does not clear");
        pins(4'b0010);
        pins(4'b1010);
        chk_pins(5'b10111, "enable rise clears short");
        done("short");
        rd_chk(`HBFP_OFS_INT_STAT, 32'h1, "short event");
        apb(1'b1, `HBFP_OFS_INT_MASK, 32'h1);
        step(2);
        check({31'h0, irq}, 32'h1, "irq unmasked");
        apb(1'b1, `HBFP_OFS_INT_STAT, 32'h1);
        step(2);
        check({31'h0, irq}, 32'h0, "irq cleared");
        rd_chk(`HBFP_OFS_INT_STAT, 32'h0, "event cleared");
        apb(1'b1, `HBFP_OFS_INT_MASK, 32'h0);
        done("interrupt");
        pins(4'b1001);
        sense.cur_limit <= 1'b1;
        step(2);
        sense.cur_limit <= 1'b0;
        step(4);
        chk_pins(5'b00001, "limit off early");
        step(10);
        chk_pins(5'b00001, "limit off late");
        step(14);
        chk_pins(5'b11101, "limit back on");
        sense.temp_fold <= 1'b1;
        step(6);
        check({31'h0, fold_sel}, 32'h1, "reduced limit hot");
        sense.temp_fold <= 1'b0;
        step(6);
        check({31'h0, fold_sel}, 32'h0, "normal limit");
        done("limit");
        sense.temp_fold <= 1'b1;
        sense.temp_shut <= 1'b1;
        sense.temp_release <= 1'b1;
        step(8);
        chk_pins(5'b00000, "overtemp shutdown");
        rd_chk(`HBFP_OFS_STATUS, 32'h12, "overtemp status");
        sense.temp_shut <= 1'b0;
        step(8);
        chk_pins(5'b00000, "overtemp latched");
        pins(4'b1101);
        pins(4'b1001);
        chk_pins(5'b00000, "disable edge too hot");
        pins(4'b0001);
        pins(4'b1001);
        chk_pins(5'b11101, "enable edge clears");
        sense.temp_shut <= 1'b1;
        step(8);
        sense.temp_shut <= 1'b0;
        sense.temp_release <= 1'b0;
        sense.temp_fold <= 1'b0;
        step(8);
        chk_pins(5'b00000, "overtemp latched again");
        pins(4'b1101);
        pins(4'b1001);
        chk_pins(5'b11101, "disable edge clears cool");
        done("overtemp");
        sense.uvolt <= 1'b1;
        step(8);
        chk_pins(5'b00000, "undervoltage off");
        sense.uvolt <= 1'b0;
        step(8);
        chk_pins(5'b11101, "undervoltage recovers");
        rd_chk(`HBFP_OFS_INT_STAT, 32'he, "limit otemp uvolt events");
        check({31'h0, irq}, 32'h0, "masked irq low");
        done("undervoltage");
        apb(1'b1, `HBFP_OFS_CTRL, 32'h1);
        step(6);
        chk_pins(5'b00001, "inhibit off");
        rd_chk(`HBFP_OFS_CTRL, 32'h1, "ctrl readback");
        apb(1'b1, `HBFP_OFS_CTRL, 32'h0);
        step(6);
        chk_pins(5'b11101, "inhibit removed");
        apb(1'b1, `HBFP_OFS_STATUS, 32'hffffffff);
        rd_chk(`HBFP_OFS_STATUS, 32'h0, "status read only");
        apb(1'b0, 12'h010, 32'h0);
        check({31'h0, er}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        pstrb <= 4'h0;
        apb(1'b1, `HBFP_OFS_INT_MASK, 32'h1);
        pstrb <= 4'hf;
        rd_chk(`HBFP_OFS_INT_MASK, 32'h0, "write without strobe dropped");
        done("registers");
        sense.short_det <= 1'b1;
        step(8);
        sense.short_det <= 1'b0;
        step(4);
        chk_pins(5'b00000, "short before power cycle");
        presetn <= 1'b0;
        step(2);
        presetn <= 1'b1;
        step(8);
        check({31'h0, pin_view[0]}, 32'h1, "power cycle releases flag");
        rd_chk(`HBFP_OFS_STATUS, 32'h0, "power cycle clears latch");
        done("power");
        final_report;
    end
endmodule : hbfp_top_bench
`default_nettype wire
